// *** rtl/rss_unit.sv ***
// Purpose: rotate, arithmetic shift, subtract-with-borrow and count-then-branch datapath
// Assumes: single AHB-Lite master, zero wait states, whole-word transfers
// Notes: an operation runs in the cycle after a control write with the go bit set
`timescale 1ns/1ps

module rss_unit import rss_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [15:0] src_reg;
	logic [15:0] src_next;
	logic [31:0] dest_reg;
	logic [31:0] dest_next;
	logic [3:0] flags_reg;
	logic [3:0] flags_next;
	logic [2:0] status_reg;
	logic [2:0] status_next;
	rss_state_type state_reg;
	rss_state_type state_next;
	logic wrPend_reg;
	logic [7:0] wrAddr_reg;
	logic [31:0] rdMux;

	// request and answer lines of the bit engine
	rss_shift_if shiftBus ();

	// --------------------------------------------------------------
	// bus slave decode
	// --------------------------------------------------------------
	logic busAccept;
	logic wrCtrl;
	logic wrSrc;
	logic wrDest;
	logic wrFlags;
	logic goWrite;
	logic execNow;
	logic rdCtrl;
	logic rdSrc;
	logic rdDest;
	logic rdFlags;
	logic rdStatus;
	logic [31:0] statusWord;

	// one register offset against an address byte; shared by write and read decode
	function automatic logic rss_off_hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : rss_off_hit

	// address phase taken when selected, ready and non-sequential or sequential
	assign busAccept = hsel & hready & htrans[1];
	assign wrCtrl = wrPend_reg && rss_off_hit(wrAddr_reg, RSS_OFF_CTRL);
	assign wrSrc = wrPend_reg && rss_off_hit(wrAddr_reg, RSS_OFF_SRC);
	assign wrDest = wrPend_reg && rss_off_hit(wrAddr_reg, RSS_OFF_DEST);
	assign wrFlags = wrPend_reg && rss_off_hit(wrAddr_reg, RSS_OFF_FLAGS);
	assign goWrite = wrCtrl & hwdata[RSS_CTRL_GO_BIT];
	assign execNow = (state_reg == RSS_ST_EXEC);

	// address phase hits for the read mux
	assign rdCtrl = rss_off_hit(haddr[7:0], RSS_OFF_CTRL);
	assign rdSrc = rss_off_hit(haddr[7:0], RSS_OFF_SRC);
	assign rdDest = rss_off_hit(haddr[7:0], RSS_OFF_DEST);
	assign rdFlags = rss_off_hit(haddr[7:0], RSS_OFF_FLAGS);
	assign rdStatus = rss_off_hit(haddr[7:0], RSS_OFF_STATUS);

	// status word: stored bits plus busy during the execute cycle
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[RSS_STAT_DONE] = status_reg[RSS_STAT_DONE];
		statusWord[RSS_STAT_BRANCH] = status_reg[RSS_STAT_BRANCH];
		statusWord[RSS_STAT_INVALID] = status_reg[RSS_STAT_INVALID];
		statusWord[RSS_STAT_BUSY] = execNow;
	end

	// read mux for the address phase
	always_comb begin
		if (rdCtrl) begin
			rdMux = ctrl_reg;
		end else if (rdSrc) begin
			rdMux = {16'h0000, src_reg};
		end else if (rdDest) begin
			rdMux = dest_reg;
		end else if (rdFlags) begin
			rdMux = {28'h000_0000, flags_reg};
		end else if (rdStatus) begin
			rdMux = statusWord;
		end else begin
			rdMux = 32'h0000_0000;
		end
	end

	// --------------------------------------------------------------
	// control field decode
	// --------------------------------------------------------------
	rss_op_type opSel;
	rss_size_type sizeSel;
	logic countImm;
	logic destIsAddr;
	logic subForm;
	logic [7:0] countVal;
	logic countNeg;
	logic [7:0] countMag;
	logic immValid;
	logic isShiftOp;
	logic shiftSkip;
	logic [31:0] sizeMask;
	logic countRefused;

	// raw fields of the stored control word
	assign opSel = rss_op_type'(ctrl_reg[RSS_CTRL_OP_LSB +: 2]);
	assign sizeSel = rss_size_type'(ctrl_reg[RSS_CTRL_SIZE_LSB +: 2]);
	assign countImm = ctrl_reg[RSS_CTRL_IMM_BIT];
	assign destIsAddr = ctrl_reg[RSS_CTRL_DADDR_BIT];
	assign subForm = ctrl_reg[RSS_CTRL_SUBFORM_BIT];
	assign countVal = ctrl_reg[RSS_CTRL_COUNT_LSB +: 8];
	assign sizeMask = rss_size_mask(sizeSel);
	// count sign picks direction, magnitude picks distance
	assign countNeg = countVal[7];
	assign countMag = countNeg ? 8'(8'h00 - countVal) : countVal;
	// immediate form refuses zero and magnitudes past eight
	assign immValid = (countVal != 8'h00) && (countMag <= RSS_IMM_COUNT_MAX);
	assign isShiftOp = (opSel == RSS_OP_ROTATE) || (opSel == RSS_OP_ASHIFT);
	// zero or refused count: no data or flag change
	// an immediate count outside the legal set is reported and changes nothing
	assign countRefused = isShiftOp && countImm && !immValid;
	assign shiftSkip = isShiftOp && (countImm ? !immValid : (countVal == 8'h00));

	// --------------------------------------------------------------
	// rotate and shift through the bit engine
	// --------------------------------------------------------------
	logic [31:0] shiftRes;
	logic shiftMsb;
	logic shiftZero;
	logic shiftOvf;
	logic shiftOvfLive;

	// engine request from the stored control word and destination
	assign shiftBus.operand = dest_reg;
	assign shiftBus.size = sizeSel;
	assign shiftBus.left = !countNeg;
	assign shiftBus.rotate = (opSel == RSS_OP_ROTATE);
	// magnitudes past sixteen are undefined; low bits are used as they stand
	assign shiftBus.magnitude = countMag[4:0];

	rss_shift_engine u_engine (
		.eng(shiftBus.engine)
	);

	// upper bits outside the size survive
	assign shiftRes = (dest_reg & ~sizeMask) | (shiftBus.result & sizeMask);
	assign shiftMsb = shiftRes[rss_msb_index(sizeSel)];
	assign shiftZero = ((shiftRes & sizeMask) == 32'h0000_0000);
	// long shifts keep overflow; rotates never touch it
	assign shiftOvfLive = (opSel == RSS_OP_ASHIFT) && (sizeSel != RSS_SZ_LONG);
	assign shiftOvf = shiftOvfLive ? shiftBus.msbChanged : flags_reg[RSS_FLAG_O];

	// --------------------------------------------------------------
	// subtract with borrow
	// --------------------------------------------------------------
	logic subWide;
	logic [15:0] subA;
	logic [15:0] subB;
	logic [16:0] subDiff;
	logic subAMsb;
	logic subBMsb;
	logic subRMsb;
	logic subZero;
	logic subOvf;
	logic [31:0] subRes;

	// byte size with address destination runs at 16 bits
	assign subWide = (sizeSel != RSS_SZ_BYTE) || destIsAddr;
	assign subA = subWide ? dest_reg[15:0] : {8'h00, dest_reg[7:0]};
	// byte size takes only the low byte of the source, zero-extended
	assign subB = (sizeSel == RSS_SZ_BYTE) ? {8'h00, src_reg[7:0]} : src_reg;
	assign subDiff = {1'b0, subA} - {1'b0, subB} - {16'h0000, ~flags_reg[RSS_FLAG_C]};
	assign subAMsb = subWide ? subA[15] : subA[7];
	assign subBMsb = subWide ? subB[15] : subB[7];
	assign subRMsb = subWide ? subDiff[15] : subDiff[7];
	assign subZero = subWide ? (subDiff[15:0] == 16'h0000) : (subDiff[7:0] == 8'h00);
	// signed overflow: operands differ in sign and result sign differs from minuend
	assign subOvf = (subAMsb != subBMsb) && (subRMsb != subAMsb);
	assign subRes = subWide ? {dest_reg[31:16], subDiff[15:0]} : {dest_reg[31:8], subDiff[7:0]};

	// --------------------------------------------------------------
	// count then branch if nonzero, add and subtract forms
	// --------------------------------------------------------------
	logic [15:0] brImm;
	logic [15:0] brAddend;
	logic [15:0] brSum;
	logic brNonZero;
	logic [31:0] brRes;

	assign brImm = {{8{countVal[7]}}, countVal};
	// subtract form is the add path with the immediate negated
	assign brAddend = subForm ? 16'(16'h0000 - brImm) : brImm;
	assign brSum = 16'(dest_reg[15:0] + brAddend);
	assign brNonZero = (sizeSel == RSS_SZ_BYTE) ? (brSum[7:0] != 8'h00) : (brSum != 16'h0000);
	assign brRes = (sizeSel == RSS_SZ_BYTE) ? {dest_reg[31:8], brSum[7:0]} : {dest_reg[31:16], brSum};

	// --------------------------------------------------------------
	// result and flag selection
	// --------------------------------------------------------------
	logic [31:0] execDest;
	logic [3:0] execFlags;
	logic execBranch;

	// one operation's result, flags and branch outcome
	always_comb begin
		execDest = dest_reg;
		execFlags = flags_reg;
		execBranch = 1'b0;
		case (opSel)
			RSS_OP_ROTATE, RSS_OP_ASHIFT: begin
				if (!shiftSkip) begin
					execDest = shiftRes;
					execFlags[RSS_FLAG_C] = shiftBus.carryOut;
					execFlags[RSS_FLAG_Z] = shiftZero;
					execFlags[RSS_FLAG_S] = shiftMsb;
					execFlags[RSS_FLAG_O] = shiftOvf;
				end
			end
			RSS_OP_SUB_BORROW: begin
				execDest = subRes;
				execFlags[RSS_FLAG_C] = ~subDiff[16];
				execFlags[RSS_FLAG_Z] = subZero;
				execFlags[RSS_FLAG_S] = subRMsb;
				execFlags[RSS_FLAG_O] = subOvf;
			end
			default: begin
				// flags stay as they were
				execDest = brRes;
				execBranch = brNonZero;
			end
		endcase
	end

	// --------------------------------------------------------------
	// next-value selection for the register file
	// --------------------------------------------------------------
	// go bit is a strobe and is never stored
	assign ctrl_next = wrCtrl ? (hwdata & ~(32'h0000_0001 << RSS_CTRL_GO_BIT)) : ctrl_reg;
	assign src_next = wrSrc ? hwdata[15:0] : src_reg;
	// an executing operation wins over a bus write in the same cycle
	assign dest_next = execNow ? execDest : (wrDest ? hwdata : dest_reg);
	assign flags_next = execNow ? execFlags : (wrFlags ? hwdata[3:0] : flags_reg);
	// done is set by completion and cleared by a new go; the set wins
	assign status_next[RSS_STAT_DONE] = execNow ? 1'b1 : (goWrite ? 1'b0 : status_reg[RSS_STAT_DONE]);
	assign status_next[RSS_STAT_BRANCH] = execNow ? execBranch : status_reg[RSS_STAT_BRANCH];
	assign status_next[RSS_STAT_INVALID] = execNow ? countRefused : status_reg[RSS_STAT_INVALID];

	// sequencer: one execute cycle per go
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			RSS_ST_IDLE: begin
				if (goWrite) begin
					state_next = RSS_ST_EXEC;
				end
			end
			default: begin
				state_next = goWrite ? RSS_ST_EXEC : RSS_ST_IDLE;
			end
		endcase
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	// bus pipeline and answer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wrPend_reg <= busAccept & hwrite;
			wrAddr_reg <= busAccept ? haddr[7:0] : wrAddr_reg;
			hrdata <= (busAccept & !hwrite) ? rdMux : hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// operand, flag and status registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= RSS_CTRL_RESET;
			src_reg <= RSS_SRC_RESET;
			dest_reg <= RSS_DEST_RESET;
			flags_reg <= RSS_FLAGS_RESET;
			status_reg <= RSS_STATUS_RESET;
			state_reg <= RSS_ST_IDLE;
		end else begin
			ctrl_reg <= ctrl_next;
			src_reg <= src_next;
			dest_reg <= dest_next;
			flags_reg <= flags_next;
			status_reg <= status_next;
			state_reg <= state_next;
		end
	end

endmodule : rss_unit

// *** rtl/rss_pkg.sv ***
// Purpose: shared constants, types and size helpers of the rotate/shift/subtract unit
// Assumes: 32-bit AHB-Lite register window, one clock domain
// Notes: offsets are byte addresses within the slave window
package rss_pkg;

	// --------------------------------------------------------------
	// operation, size and sequencer types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {RSS_OP_ROTATE, RSS_OP_ASHIFT, RSS_OP_SUB_BORROW, RSS_OP_ADD_BRANCH} rss_op_type;
	typedef enum logic [1:0] {RSS_SZ_BYTE, RSS_SZ_WORD, RSS_SZ_LONG, RSS_SZ_SPARE} rss_size_type;
	typedef enum logic {RSS_ST_IDLE, RSS_ST_EXEC} rss_state_type;

	// --------------------------------------------------------------
	// register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] RSS_OFF_CTRL = 8'h00;
	localparam logic [7:0] RSS_OFF_SRC = 8'h04;
	localparam logic [7:0] RSS_OFF_DEST = 8'h08;
	localparam logic [7:0] RSS_OFF_FLAGS = 8'h0C;
	localparam logic [7:0] RSS_OFF_STATUS = 8'h10;

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int RSS_CTRL_OP_LSB = 0;
	localparam int RSS_CTRL_SIZE_LSB = 2;
	localparam int RSS_CTRL_IMM_BIT = 4;
	localparam int RSS_CTRL_DADDR_BIT = 5;
	localparam int RSS_CTRL_SADDR_BIT = 6;
	localparam int RSS_CTRL_SUBFORM_BIT = 7;
	localparam int RSS_CTRL_COUNT_LSB = 8;
	localparam int RSS_CTRL_GO_BIT = 31;
	localparam int RSS_FLAG_C = 0;
	localparam int RSS_FLAG_Z = 1;
	localparam int RSS_FLAG_S = 2;
	localparam int RSS_FLAG_O = 3;
	localparam int RSS_STAT_DONE = 0;
	localparam int RSS_STAT_BRANCH = 1;
	localparam int RSS_STAT_INVALID = 2;
	localparam int RSS_STAT_BUSY = 3;

	// --------------------------------------------------------------
	// reset values and count limits
	// --------------------------------------------------------------
	localparam logic [31:0] RSS_CTRL_RESET = 32'h0000_0000;
	localparam logic [15:0] RSS_SRC_RESET = 16'h0000;
	localparam logic [31:0] RSS_DEST_RESET = 32'h0000_0000;
	localparam logic [3:0] RSS_FLAGS_RESET = 4'h0;
	localparam logic [2:0] RSS_STATUS_RESET = 3'h0;
	localparam logic [7:0] RSS_IMM_COUNT_MAX = 8'h08;

	// --------------------------------------------------------------
	// size helpers
	// --------------------------------------------------------------
	function automatic logic [31:0] rss_size_mask(input rss_size_type sz);
		logic [31:0] m;
		case (sz)
			RSS_SZ_BYTE: m = 32'h0000_00FF;
			RSS_SZ_WORD: m = 32'h0000_FFFF;
			default: m = 32'hFFFF_FFFF;
		endcase
		return m;
	endfunction : rss_size_mask

	function automatic logic [4:0] rss_msb_index(input rss_size_type sz);
		logic [4:0] i;
		case (sz)
			RSS_SZ_BYTE: i = 5'h07;
			RSS_SZ_WORD: i = 5'h0F;
			default: i = 5'h1F;
		endcase
		return i;
	endfunction : rss_msb_index

endpackage : rss_pkg

// *** rtl/rss_shift_if.sv ***
// Purpose: carries one rotate or shift request to the bit engine and its answer back
// Assumes: purely combinational exchange within one clock cycle
// Notes: requester drives operand and control, engine drives result and carry
`timescale 1ns/1ps
interface rss_shift_if import rss_pkg::*; ();
	logic [31:0] operand;
	rss_size_type size;
	logic left;
	logic rotate;
	logic [4:0] magnitude;
	logic [31:0] result;
	logic carryOut;
	logic msbChanged;

	modport requester (output operand, size, left, rotate, magnitude, input result, carryOut, msbChanged);
	modport engine (input operand, size, left, rotate, magnitude, output result, carryOut, msbChanged);
endinterface : rss_shift_if

// *** rtl/rss_shift_engine.sv ***
// Purpose: multi-bit rotate and arithmetic shift of a byte, word or long operand
// Assumes: magnitude 0..31 from the caller; no more than 16 steps are taken
// Notes: bits above the selected size come out as zero
`timescale 1ns/1ps
module rss_shift_engine import rss_pkg::*; (
	rss_shift_if.engine eng
);

	// --------------------------------------------------------------
	// step loop, one bit position per iteration
	// --------------------------------------------------------------
	always_comb begin
		logic [31:0] mask;
		logic [31:0] v;
		logic [4:0] msbIdx;
		logic origMsb;
		logic c;
		logic chg;
		logic top;
		mask = rss_size_mask(eng.size);
		msbIdx = rss_msb_index(eng.size);
		v = eng.operand & mask;
		origMsb = v[msbIdx];
		c = 1'b0;
		chg = 1'b0;
		top = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (5'(i) < eng.magnitude) begin
				if (eng.left) begin
					// leaving msb goes to carry, and to bit 0 when rotating
					c = v[msbIdx];
					v = (v << 1) & mask;
					if (eng.rotate) begin
						v[0] = c;
					end
				end else begin
					// leaving lsb goes to carry; top takes sign or the rotated bit
					c = v[0];
					top = eng.rotate ? c : v[msbIdx];
					v = v >> 1;
					v[msbIdx] = top;
				end
				chg = chg | (v[msbIdx] != origMsb);
			end
		end
		eng.result = v;
		eng.carryOut = c;
		eng.msbChanged = chg;
	end

endmodule : rss_shift_engine

// *** verification/rss_ahb_master.sv ***
// Purpose: register bus master standing in for the core's decoder and register file
// Assumes: one zero-or-more wait slave, single whole-word transfers
// Notes: write data is inverted once the data phase is over
`timescale 1ns/1ps
module rss_ahb_master (
	input wire logic clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// bus idle at time zero
	initial begin
		hsel = 1'h0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
	end

	// ------------------------------------------------------------
	// one transfer: address phase, data phase, both held to hready
	// ------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, off};
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= wr ? wd : ~hwdata;
		do @(posedge clk); while (hready !== 1'h1);
		rd = hrdata;
		hwdata <= ~hwdata; // released bus no longer shows the data
	endtask : xfer
endmodule : rss_ahb_master

// *** verification/rss_unit_properties.sv ***
// Purpose: bus-side properties of the rotate/shift/subtract unit
// Assumes: one clock domain, single slave on the bus
// Notes: sees the top ports only
`timescale 1ns/1ps
module rss_unit_properties import rss_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp
);
	// address phase decode
	wire logic rdAp = hsel & hready & htrans[1] & ~hwrite;
	wire logic wrAp = hsel & hready & htrans[1] & hwrite;
	wire logic [7:0] off = haddr[7:0];
	logic wrPend_reg;
	logic [7:0] wrOff_reg;
	logic [15:0] srcShadow_reg;
	wire logic srcWr = wrPend_reg & (wrOff_reg == RSS_OFF_SRC);

	// write data phase and source shadow
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPend_reg <= 1'h0;
			wrOff_reg <= 8'h00;
			srcShadow_reg <= 16'h0000;
		end else begin
			wrPend_reg <= wrAp;
			wrOff_reg <= off;
			if (srcWr)
				srcShadow_reg <= hwdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_okay; hresp == 1'h0; endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_ready; hreadyout == 1'h1; endproperty
	a_ready: assert property (p_ready) else $error("wait state inserted");
	property p_unmapped; rdAp && off > 8'h13 |=> hrdata == 32'h0000_0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_go_low; rdAp && off == RSS_OFF_CTRL |=> !hrdata[RSS_CTRL_GO_BIT]; endproperty
	a_go_low: assert property (p_go_low) else $error("go bit reads back");
	property p_status_hi; rdAp && off == RSS_OFF_STATUS |=> hrdata[31:4] == 28'h000_0000; endproperty
	a_status_hi: assert property (p_status_hi) else $error("status upper bits set");
	property p_flags_hi; rdAp && off == RSS_OFF_FLAGS |=> hrdata[31:4] == 28'h000_0000; endproperty
	a_flags_hi: assert property (p_flags_hi) else $error("flags upper bits set");
	property p_src_back; rdAp && off == RSS_OFF_SRC && !srcWr |=> hrdata == {16'h0000, srcShadow_reg}; endproperty
	a_src_back: assert property (p_src_back) else $error("source readback wrong");
	property p_hold; !rdAp |=> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule : rss_unit_properties

bind rss_unit rss_unit_properties u_props (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.hresp(hresp));

// *** verification/rss_unit_tb_top.sv ***
// Purpose: self-checking bench of the rotate/shift/subtract unit
// Assumes: zero-wait slave, bus master model drives all bus inputs except hready, which loops back from hreadyout
// Notes: flags word is {O,S,Z,C}; long shift zero and carry are masked
`timescale 1ns/1ps
module rss_unit_tb_top import rss_pkg::*; ;
	logic clk;
	logic nrst;
	wire logic hsel, hwrite, hreadyout, hresp;
	wire logic [31:0] haddr, hwdata, hrdata;
	wire logic [1:0] htrans;
	wire logic [2:0] hsize;
	int bad_count = 0;
	int cmp_count = 0;

	// clock
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	rss_unit dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
	rss_ahb_master bus (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		logic [31:0] q;
		bus.xfer(1'h1, off, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] off, output logic [31:0] q);
		bus.xfer(1'h0, off, 32'h0000_0000, q);
	endtask : rd

	// load operands, start, then judge dest, flags and status
	task automatic op(input logic [15:0] c, input logic [15:0] s, input logic [31:0] d, input logic [3:0] f,
		input logic [31:0] ed, input logic [3:0] ef, input logic [2:0] es);
		logic [31:0] q;
		logic [3:0] fm;
		logic [31:0] sm;
		fm = (c[3:0] == 4'h9) ? 4'hC : 4'hF;
		sm = {28'h000_0000, 2'h3, &c[1:0], 1'h1};
		wr(RSS_OFF_SRC, {16'h0000, s});
		wr(RSS_OFF_DEST, d);
		wr(RSS_OFF_FLAGS, {28'h000_0000, f});
		wr(RSS_OFF_CTRL, {16'h8000, c});
		rd(RSS_OFF_DEST, q);
		chk(q, ed);
		rd(RSS_OFF_FLAGS, q);
		chk(q & {28'h000_0000, fm}, {28'h000_0000, ef & fm});
		rd(RSS_OFF_STATUS, q);
		chk(q & sm, {29'h0000_0000, es} & sm);
	endtask : op

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] q;
		for (int a = 0; a < 24; a += 4) begin
			rd(a[7:0], q);
			chk(q, 32'h0000_0000);
		end
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, q);
		chk(q, 32'h0000_0000);
		wr(RSS_OFF_CTRL, 32'h0000_0301);
		rd(RSS_OFF_CTRL, q);
		chk(q, 32'h0000_0301);
		wr(RSS_OFF_SRC, 32'hABCD_1234);
		rd(RSS_OFF_SRC, q);
		chk(q, 32'h0000_1234);
		$display("reset test done");
	endtask : t_reset

	task automatic t_rotate();
		op(16'h0110, 16'h0000, 32'h0000_0081, 4'h0, 32'h0000_0003, 4'h1, 3'h1);
		op(16'hFF10, 16'h0000, 32'h0000_0081, 4'h0, 32'h0000_00C0, 4'h5, 3'h1);
		op(16'h0800, 16'h0000, 32'h1234_56A5, 4'h8, 32'h1234_56A5, 4'hD, 3'h1);
		op(16'hF004, 16'h0000, 32'h0000_8001, 4'h0, 32'h0000_8001, 4'h5, 3'h1);
		op(16'h0004, 16'h0000, 32'h0000_0000, 4'hF, 32'h0000_0000, 4'hF, 3'h1);
		op(16'h0000, 16'h0000, 32'h0000_0055, 4'h6, 32'h0000_0055, 4'h6, 3'h1);
		op(16'h0010, 16'h0000, 32'h0000_0055, 4'h2, 32'h0000_0055, 4'h2, 3'h5);
		op(16'h0910, 16'h0000, 32'h0000_0055, 4'h2, 32'h0000_0055, 4'h2, 3'h5);
		op(16'h0414, 16'h0000, 32'h0000_F00F, 4'h0, 32'h0000_00FF, 4'h1, 3'h1);
		op(16'h0310, 16'h0000, 32'h0000_0000, 4'h0, 32'h0000_0000, 4'h2, 3'h1);
		$display("rotate test done");
	endtask : t_rotate

	task automatic t_shift();
		op(16'h0111, 16'h0000, 32'h0000_0040, 4'h0, 32'h0000_0080, 4'hC, 3'h1);
		op(16'hFD11, 16'h0000, 32'hAB00_0080, 4'h8, 32'hAB00_00F0, 4'h4, 3'h1);
		op(16'h0211, 16'h0000, 32'h0000_0081, 4'h0, 32'h0000_0004, 4'h8, 3'h1);
		op(16'h1005, 16'h0000, 32'h0000_0001, 4'h0, 32'h0000_0000, 4'hB, 3'h1);
		op(16'hF005, 16'h0000, 32'h0000_8000, 4'h0, 32'h0000_FFFF, 4'h5, 3'h1);
		op(16'h0409, 16'h0000, 32'h8000_0001, 4'h8, 32'h0000_0010, 4'h8, 3'h1);
		op(16'hF009, 16'h0000, 32'h8000_0000, 4'h0, 32'hFFFF_8000, 4'h4, 3'h1);
		op(16'h0001, 16'h0000, 32'h0000_007F, 4'h9, 32'h0000_007F, 4'h9, 3'h1);
		op(16'hF711, 16'h0000, 32'h0000_007F, 4'h9, 32'h0000_007F, 4'h9, 3'h5);
		$display("shift test done");
	endtask : t_shift

	task automatic t_subtract();
		op(16'h0002, 16'h0001, 32'h0000_0010, 4'h1, 32'h0000_000F, 4'h1, 3'h1);
		op(16'h0002, 16'h0001, 32'h0000_0010, 4'h0, 32'h0000_000E, 4'h1, 3'h1);
		op(16'h0002, 16'h0000, 32'h0000_0000, 4'h0, 32'h0000_00FF, 4'h4, 3'h1);
		op(16'h0002, 16'h0001, 32'h0000_0080, 4'h1, 32'h0000_007F, 4'h9, 3'h1);
		op(16'h0006, 16'h0005, 32'h0000_0005, 4'h1, 32'h0000_0000, 4'h3, 3'h1);
		op(16'h0006, 16'hFFFF, 32'h0000_7FFF, 4'h1, 32'h0000_8000, 4'hC, 3'h1);
		op(16'h0022, 16'h0180, 32'h0000_0100, 4'h1, 32'h0000_0080, 4'h1, 3'h1);
		$display("subtract test done");
	endtask : t_subtract

	task automatic t_branch();
		op(16'h0187, 16'h0000, 32'h0000_0001, 4'hF, 32'h0000_0000, 4'hF, 3'h1);
		op(16'h0887, 16'h0000, 32'h0000_0010, 4'h5, 32'h0000_0008, 4'h5, 3'h3);
		op(16'hF983, 16'h0000, 32'h0000_00FE, 4'h0, 32'h0000_0005, 4'h0, 3'h3);
		op(16'h0207, 16'h0000, 32'h0000_FFFE, 4'hA, 32'h0000_0000, 4'hA, 3'h1);
		$display("branch test done");
	endtask : t_branch

	// verdict and end of run
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	// main sequence
	initial begin
		nrst = 1'h0;
		repeat (8) @(posedge clk);
		nrst <= 1'h1;
		t_reset();
		t_rotate();
		t_shift();
		t_subtract();
		t_branch();
		test_done();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		test_done();
	end
endmodule : rss_unit_tb_top
